// >>> hw/sar_ctl_consts.vh
// Constants for the dual SAR converter sample control.
`ifndef SAR_CTL_CONSTS_VH
`define SAR_CTL_CONSTS_VH
`define RES_BITS          14
`define RES_BITS_SHORT    12
`define RANGE_BIP10       2'h0
`define RANGE_BIP5        2'h1
`define RANGE_UNI10       2'h2
`define RANGE_BAD         2'h3
`define CHAN_FIRST        1'h0
`define SETTLE_CYCLES     4'h2
`define MIDSCALE_14       14'h2000
`endif

// >>> hw/sar_stepper.v
// Successive-approximation stepper for one converter.
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctl_consts.vh"
module sar_stepper (
  input  wire                   ref_clk_i,
  input  wire                   rst_i,
  input  wire                   start_i,
  input  wire                   comp_high_i,
  output reg  [`RES_BITS-1:0]   dac_code_o,
  output reg                    done_o
);
  reg [`RES_BITS-1:0] trial_bit_r;
  reg                 active_r;
  reg                 settle_r;

  // [RL11] Step DAC to balance.
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      dac_code_o  <= 14'h0000;
      trial_bit_r <= 14'h0000;
      active_r    <= 1'b0;
      settle_r    <= 1'b0;
      done_o      <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        dac_code_o  <= `MIDSCALE_14;
        trial_bit_r <= `MIDSCALE_14;
        active_r    <= 1'b1;
        settle_r    <= 1'b0;
      end else if (active_r) begin
        // The trial reaches the comparator through a registered DAC port,
        // one clock late, so each trial settles a cycle before judgement.
        settle_r <= ~settle_r;
        if (settle_r) begin
          // A high comparator means the trial overshot, so drop that bit.
          if (comp_high_i)
            dac_code_o <= (dac_code_o & ~trial_bit_r) | (trial_bit_r >> 1);
          else
            dac_code_o <= dac_code_o | (trial_bit_r >> 1);
          trial_bit_r <= trial_bit_r >> 1;
          if (trial_bit_r == 14'h0001) begin
            active_r <= 1'b0;
            done_o   <= 1'b1;
            if (comp_high_i)
              dac_code_o <= dac_code_o & ~trial_bit_r;
          end
        end
      end
    end
  end
endmodule // sar_stepper
`default_nettype wire

// >>> hw/dual_sar_adc_sample_control.v
// Sequencing, range and channel control of a dual SAR converter.
//
// Contract
// [RL1] Range pins pick one of three ranges.
// [RL2] Host keeps range steady during acquisition.
// [RL3] Channel pin low first, high second.
// [RL4] Channel captured at busy rise, next conversion.
// [RL5] Power-up default is first input pair.
// [RL6] Results are twos-complement coded.
// [RL7] Code steps at whole LSB levels.
// [RL8] Track resumes when busy falls.
// [RL9] Hold on conversion start falling edge.
// [RL10] Host allows 140 ns tracking first.
// [RL11] SAR steps DAC until comparator balances.
// [RL12] One falling edge starts both conversions.
// [RL13] Busy high throughout, low when both done.
// [RL14] Range at start scales that result.
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctl_consts.vh"
module dual_sar_adc_sample_control (
  input  wire                   ref_clk_i,
  input  wire                   rst_i,
  input  wire                   range_select_low_i,
  input  wire                   range_select_high_i,
  input  wire                   channel_select_i,
  input  wire                   conversion_start_n_i,
  input  wire                   short_result_i,
  input  wire                   comp_a_high_i,
  input  wire                   comp_b_high_i,
  output reg                    busy_o,
  output reg                    hold_o,
  output reg                    chan_second_o,
  output reg  [1:0]             range_o,
  output reg                    range_fault_o,
  output reg  [`RES_BITS-1:0]   dac_a_o,
  output reg  [`RES_BITS-1:0]   dac_b_o,
  output reg  [`RES_BITS-1:0]   result_a_o,
  output reg  [`RES_BITS-1:0]   result_b_o,
  output reg                    result_valid_o
);
  localparam ST_TRACK = 3'h1;
  localparam ST_CONV  = 3'h2;
  localparam ST_END   = 3'h4;

  // Start, channel and range pins cross from the host domain; two flops each before use.
  reg [3:0] sync1_r;
  reg [3:0] sync2_r;
  reg       start_prev_r;
  reg [2:0] state_r;
  reg       done_a_r;
  reg       done_b_r;
  // Channel captured at busy rise waits here until the next conversion.
  reg       chan_next_r;
  wire [`RES_BITS-1:0] code_a;
  wire [`RES_BITS-1:0] code_b;
  wire                 fin_a;
  wire                 fin_b;
  wire                 start_fall;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync1_r <= 4'hf;
      sync2_r <= 4'hf;
    end else begin
      sync1_r <= {conversion_start_n_i, channel_select_i,
                  range_select_high_i, range_select_low_i};
      sync2_r <= sync1_r;
    end
  end

  // [RL9] Falling edge detect.
  assign start_fall = start_prev_r & ~sync2_r[3];

  sar_stepper u_sar_a (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .start_i     (state_r == ST_TRACK && start_fall),
    .comp_high_i (comp_a_high_i),
    .dac_code_o  (code_a),
    .done_o      (fin_a)
  );

  sar_stepper u_sar_b (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .start_i     (state_r == ST_TRACK && start_fall),
    .comp_high_i (comp_b_high_i),
    .dac_code_o  (code_b),
    .done_o      (fin_b)
  );

  // The stepper yields offset binary; flipping the top bit gives twos
  // complement. The short variant drops two low bits and sign-extends.
  function [`RES_BITS-1:0] to_twos;
    input [`RES_BITS-1:0] raw;
    input                 short_res;
    begin
      if (short_res)
        to_twos = {{3{~raw[13]}}, raw[12:2]};
      else
        to_twos = {~raw[13], raw[12:0]};
    end
  endfunction

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      start_prev_r   <= 1'b1;
      state_r        <= ST_TRACK;
      busy_o         <= 1'b0;
      hold_o         <= 1'b0;
      // [RL5] First pair default.
      chan_second_o  <= `CHAN_FIRST;
      chan_next_r    <= `CHAN_FIRST;
      range_o        <= `RANGE_BIP10;
      range_fault_o  <= 1'b0;
      dac_a_o        <= 14'h0000;
      dac_b_o        <= 14'h0000;
      result_a_o     <= 14'h0000;
      result_b_o     <= 14'h0000;
      result_valid_o <= 1'b0;
      done_a_r       <= 1'b0;
      done_b_r       <= 1'b0;
    end else begin
      start_prev_r   <= sync2_r[3];
      dac_a_o        <= code_a;
      dac_b_o        <= code_b;
      result_valid_o <= 1'b0;
      case (state_r)
        ST_TRACK: begin
          if (start_fall) begin
            // [RL12] Both hold together.
            hold_o   <= 1'b1;
            // [RL13] Busy rises.
            busy_o   <= 1'b1;
            // [RL3] [RL4] Latch channel for next.
            chan_next_r <= sync2_r[2];
            // [RL1] [RL14] Range frozen here.
            range_o  <= sync2_r[1:0];
            range_fault_o <= (sync2_r[1:0] == `RANGE_BAD);
            done_a_r <= 1'b0;
            done_b_r <= 1'b0;
            state_r  <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (fin_a) done_a_r <= 1'b1;
          if (fin_b) done_b_r <= 1'b1;
          if ((done_a_r | fin_a) & (done_b_r | fin_b))
            state_r <= ST_END;
        end
        ST_END: begin
          // [RL6] [RL7] Twos-complement codes.
          result_a_o     <= to_twos(code_a, short_result_i);
          result_b_o     <= to_twos(code_b, short_result_i);
          result_valid_o <= 1'b1;
          // [RL13] Busy falls when both done.
          busy_o  <= 1'b0;
          // [RL8] Track on busy fall.
          hold_o  <= 1'b0;
          // [RL4] Captured channel applies from here.
          chan_second_o <= chan_next_r;
          state_r <= ST_TRACK;
        end
        default: state_r <= ST_TRACK;
      endcase
    end
  end
endmodule // dual_sar_adc_sample_control
`default_nettype wire

// >>> testbench/afe_model.sv
// Analog front end model: four input levels and two comparators.
`timescale 1ns/1ps
`default_nettype none
module afe_model (
  input  wire logic        sel_i,
  input  wire logic [13:0] dac_a_i,
  input  wire logic [13:0] dac_b_i,
  output wire logic        comp_a_o,
  output wire logic        comp_b_o
);
  assign comp_a_o = dac_a_i > (sel_i ? 14'h3fff : 14'h0123);
  assign comp_b_o = dac_b_i > (sel_i ? 14'h0000 : 14'h2000);
endmodule // afe_model
`default_nettype wire

// >>> testbench/sar_ctl_checker.sv
// Sequencing checks of the dual SAR sample control.
`timescale 1ns/1ps
`default_nettype none
module sar_ctl_checker (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       conversion_start_n_i,
  input wire logic       busy_o,
  input wire logic       hold_o,
  input wire logic       chan_second_o,
  input wire logic [1:0] range_o,
  input wire logic       result_valid_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_run; busy_o[*8] ##[1:40] !busy_o; endsequence
  chk_hold_start: assert property ($rose(busy_o) |-> $rose(hold_o))
    else $error("hold did not rise with busy");
  chk_hold_busy: assert property (hold_o == busy_o)
    else $error("hold and busy differ");
  chk_start_edge: assert property ($fell(conversion_start_n_i) && !busy_o
    |-> ##[1:5] busy_o)
    else $error("start edge did not raise busy");
  chk_busy_run: assert property ($rose(busy_o) |-> s_run)
    else $error("busy length wrong");
  chk_range_hold: assert property (busy_o ##1 busy_o |-> $stable(range_o))
    else $error("range moved during conversion");
  chk_chan_capture: assert property ($changed(chan_second_o) |-> $fell(busy_o))
    else $error("channel changed outside busy fall");
  chk_end_valid: assert property ($fell(busy_o) |-> result_valid_o)
    else $error("busy fell without results");
  chk_valid_pulse: assert property (result_valid_o |-> !busy_o ##1 !result_valid_o)
    else $error("result valid not a single pulse");
endmodule // sar_ctl_checker
`default_nettype wire

// >>> testbench/test_dual_sar_adc_sample_control.sv
// Self-checking bench of the dual SAR sample control.
`timescale 1ns/1ps
`default_nettype none
module test_dual_sar_adc_sample_control;
  logic        ref_clk_i = 0, rst_i = 1, rl = 0, rh = 0, ch = 0, sn = 1, sh = 0;
  logic        busy, hold, chs, rv, flt, ca, cb, cap = 0;
  logic [1:0]  rng;
  logic [13:0] da, db, ra, rb;
  int          err_count = 0, n_compared = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  dual_sar_adc_sample_control dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .range_select_low_i(rl), .range_select_high_i(rh), .channel_select_i(ch),
    .conversion_start_n_i(sn), .short_result_i(sh), .comp_a_high_i(ca),
    .comp_b_high_i(cb), .busy_o(busy), .hold_o(hold), .chan_second_o(chs),
    .range_o(rng), .range_fault_o(flt), .dac_a_o(da), .dac_b_o(db),
    .result_a_o(ra), .result_b_o(rb), .result_valid_o(rv));
  afe_model far (.sel_i(chs), .dac_a_i(da), .dac_b_i(db), .comp_a_o(ca),
    .comp_b_o(cb));
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Pins change mid-conversion to show they are ignored until the next one.
  task automatic conv(input logic r0, input logic r1, input logic c, input logic s);
    logic [13:0] va, vb;
    int n;
    // pins settle and tracking runs 160 ns before start.
    {rl, rh, ch, sh} = {r0, r1, c, s};
    repeat (16) @(negedge ref_clk_i);
    sn = 0;
    for (n = 0; n < 60 && !rv; n++) begin
      @(negedge ref_clk_i);
      if (n == 2) sn = 1;
      if (n == 8) {ch, rl} = {~c, ~r0};
    end
    va = (cap ? 14'h3fff : 14'h0123) ^ 14'h2000;
    vb = (cap ? 14'h0000 : 14'h2000) ^ 14'h2000;
    if (s) va = $signed(va) >>> 2;
    if (s) vb = $signed(vb) >>> 2;
    cap = c;
    check(rv, 1'h1);
    check(ra, va);
    check(rb, vb);
    check(chs, c);
    check(flt, r0 & r1);
    if (!(r0 & r1)) check(rng, {r1, r0});
    @(negedge ref_clk_i);
  endtask
  task automatic t_power_up;
    check(chs, 1'h0);
    check(busy, 1'h0);
  endtask
  task automatic t_ranges;
    for (int i = 0; i < 4; i++) conv(i[0], i[1], i[0], 1'h0);
  endtask
  task automatic t_short;
    conv(1'h0, 1'h0, 1'h1, 1'h1);
    conv(1'h1, 1'h0, 1'h0, 1'h1);
    conv(1'h0, 1'h0, 1'h0, 1'h0);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rst_i = 0;
    t_power_up();
    t_ranges();
    t_short();
    results();
  end
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule // test_dual_sar_adc_sample_control
bind dual_sar_adc_sample_control sar_ctl_checker chk (.ref_clk_i, .rst_i,
  .conversion_start_n_i, .busy_o, .hold_o, .chan_second_o, .range_o,
  .result_valid_o);
`default_nettype wire
